/* servo_drive_end.sv */
`timescale 1ns/10ps
`default_nettype none
module servo_drive_end #(
   parameter int MS_DIV = servo_pkg::MS_CYCLES,
   parameter servo_pkg::link_mode_t LINK_MODE = servo_pkg::LINK_RS485_ONLY
) (
   input wire logic clk_sys,                        // System clock
   input wire logic rst,                            // Synchronous reset
   servo_if.device link,                            // Signals to and from host
   input wire logic main_power_in,                  // Main power present
   input wire logic fault_in,                       // Internal alarm source
   input wire logic [15:0] motor_speed_in,          // Measured speed in r/min
   input wire logic [7:0] stall_brake_delay_setting,  // Stall delay in ms
   input wire logic [7:0] motion_brake_delay_setting, // Motion delay in ms
   input wire logic [2:0] alarm_sequence_setting,     // Alarm braking mode
   input wire logic [2:0] servo_off_sequence_setting, // Servo-off braking mode
   input wire logic [3:0] station_selector,         // Rotary address switch
   output logic energise_out,                       // Motor energised
   output logic dyn_brake_out,                      // Dynamic brake on
   output logic protect_active_out,                 // Supervision running
   output logic travel_inhibit_out,                 // Overtravel seen
   output logic station_valid_out                   // Address usable
);
   import servo_pkg::*;

   ////////////////////////////////////////////////////////////////////////////

   if (MS_DIV < 2) begin : g_div_check
      $error("servo_drive_end needs MS_DIV of at least 2");
   end

   typedef struct packed {
      logic en_s1;
      logic en_s2;
      logic fwd_s1;
      logic fwd_s2;
      logic rev_s1;
      logic rev_s2;
      logic pwr_s1;
      logic pwr_s2;
      logic flt_s1;
      logic flt_s2;
      logic [15:0] spd_s1;
      logic [15:0] spd_s2;
      logic [3:0] sel_s1;
      logic [3:0] sel_s2;
      logic [15:0] ms_cnt;
      logic [7:0] brk_cnt;
      dev_state_t state;
      logic cause_alarm;
      logic ready;
      logic protect;
      logic brake;
      logic servo_on;
      logic alarm;
      logic energise;
      logic dyn;
      logic inhibit;
      logic valid;
   } drv_state_t;

   drv_state_t s_r;
   drv_state_t s_nxt;
   logic tick;
   logic stopped;
   logic init_done;
   logic alarm_now;
   logic [2:0] seq;

   tick_divider #(
      .DIV(MS_DIV)
   ) u_ms (
      .clk_sys(clk_sys),
      .rst(rst),
      .tick(tick)
   );

   ////////////////////////////////////////////////////////////////////////////

   always_comb begin
      s_nxt = s_r;
      s_nxt.en_s1 = link.servo_enable_in;
      s_nxt.en_s2 = s_r.en_s1;
      s_nxt.fwd_s1 = link.forward_overtravel_in;
      s_nxt.fwd_s2 = s_r.fwd_s1;
      s_nxt.rev_s1 = link.reverse_overtravel_in;
      s_nxt.rev_s2 = s_r.rev_s1;
      s_nxt.pwr_s1 = main_power_in;
      s_nxt.pwr_s2 = s_r.pwr_s1;
      s_nxt.flt_s1 = fault_in;
      s_nxt.flt_s2 = s_r.flt_s1;
      s_nxt.spd_s1 = motor_speed_in;
      s_nxt.spd_s2 = s_r.spd_s1;
      s_nxt.sel_s1 = station_selector;
      s_nxt.sel_s2 = s_r.sel_s1;
      stopped = (s_r.spd_s2 < SPEED_LIMIT_RPM);
      // Time since initialization began, saturating
      if (tick && (s_r.ms_cnt != 16'hFFFF)) begin
         s_nxt.ms_cnt = 16'(s_r.ms_cnt + 1'b1);
      end
      if (tick && (s_r.brk_cnt != 8'hFF)) begin
         s_nxt.brk_cnt = 8'(s_r.brk_cnt + 1'b1);
      end
      init_done = (s_r.ms_cnt >= INIT_MS);
      s_nxt.protect = (s_r.ms_cnt >= PROTECT_MS);
      s_nxt.ready = init_done && s_r.pwr_s2;
      alarm_now = s_r.protect && s_r.flt_s2;
      s_nxt.inhibit = s_r.protect && (s_r.fwd_s2 || s_r.rev_s2);
      s_nxt.valid = (s_r.sel_s2 >= STATION_MIN) && (s_r.sel_s2 <= STATION_MAX);
      if (LINK_MODE == LINK_RS232_SINGLE) begin
         s_nxt.valid = 1'b1;
      end

      case (s_r.state)
         S_INIT: begin
            if (init_done) begin
               s_nxt.state = S_OFF;
            end
         end
         S_OFF: begin
            if (alarm_now) begin
               s_nxt.state = S_ALARM;
               s_nxt.cause_alarm = 1'b1;
            end else if (s_r.en_s2 && s_r.ready && stopped) begin
               s_nxt.state = S_ON;
               s_nxt.cause_alarm = 1'b0;
            end
         end
         S_ON: begin
            s_nxt.brk_cnt = 8'h00;
            if (alarm_now) begin
               s_nxt.cause_alarm = 1'b1;
               s_nxt.state = stopped ? S_ALARM : S_MOTION_WAIT;
            end else if (!s_r.en_s2 || !s_r.ready) begin
               s_nxt.cause_alarm = 1'b0;
               s_nxt.state = stopped ? S_STALL_HOLD : S_MOTION_WAIT;
            end
         end
         S_STALL_HOLD: begin
            if (alarm_now) begin
               s_nxt.state = S_ALARM;
               s_nxt.cause_alarm = 1'b1;
            end else if (s_r.brk_cnt >= stall_brake_delay_setting) begin
               s_nxt.state = S_OFF;
            end
         end
         S_MOTION_WAIT: begin
            if (alarm_now) begin
               s_nxt.cause_alarm = 1'b1;
            end
            if ((s_r.brk_cnt >= motion_brake_delay_setting) || stopped) begin
               s_nxt.state = (s_r.cause_alarm || alarm_now) ? S_ALARM : S_OFF;
            end
         end
         S_ALARM: begin
            if (!s_r.flt_s2) begin
               s_nxt.state = S_OFF;
            end
         end
         default: begin
            s_nxt.state = S_INIT;
         end
      endcase

      // Outputs follow the next state
      seq = s_nxt.cause_alarm ? alarm_sequence_setting : servo_off_sequence_setting;
      s_nxt.servo_on = (s_nxt.state == S_ON);
      s_nxt.brake = (s_nxt.state == S_ON) || (s_nxt.state == S_MOTION_WAIT);
      s_nxt.alarm = s_nxt.cause_alarm &&
                    ((s_nxt.state == S_ALARM) || (s_nxt.state == S_MOTION_WAIT));
      case (s_nxt.state)
         S_ON, S_STALL_HOLD: begin
            s_nxt.energise = 1'b1;
         end
         S_MOTION_WAIT: begin
            s_nxt.energise = !s_nxt.cause_alarm && seq[SEQ_ENERGISED];
         end
         default: begin
            s_nxt.energise = 1'b0;
         end
      endcase
      case (s_nxt.state)
         S_OFF, S_MOTION_WAIT, S_ALARM: begin
            s_nxt.dyn = !s_nxt.energise &&
                        (stopped ? seq[SEQ_DB_STOP] : seq[SEQ_DB_DECEL]);
         end
         default: begin
            s_nxt.dyn = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_r <= '0;
         s_r.state <= S_INIT;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign link.servo_ready = s_r.ready;
   assign link.brake_release_out = s_r.brake;
   assign link.servo_on = s_r.servo_on;
   assign link.alarm = s_r.alarm;
   assign energise_out = s_r.energise;
   assign dyn_brake_out = s_r.dyn;
   assign protect_active_out = s_r.protect;
   assign travel_inhibit_out = s_r.inhibit;
   assign station_valid_out = s_r.valid;
endmodule : servo_drive_end
`default_nettype wire

/* servo_pkg.sv */
// What this block does
// - At most fifteen drivers per host
// - Station selector must be 1 through F; LINK_RS232_SINGLE accepts any value
// - Host links point-to-point, drivers chain onward
// - Enable ignored until initialization completes
// - Ready needs initialization done and main power
// - Protection active 1.5 s after initialization begins
// - Host settles protection inputs before supervision
// - Motion brake delay ends at earlier event
// - Alarm at stall engages brake at once
// - Stall servo-off holds energy for stall delay
// - No servo-on above 30 r/min
// - Re-enable during deceleration waits for stop
// - Alarm dynamic braking follows alarm sequence
// - Servo-off braking follows servo-off sequence; after an alarm clears, S_OFF keeps the alarm sequence
// - Host avoids toggling enable while moving
// - Motion delay spans free-run to brake
package servo_pkg;
   localparam int CLK_HZ = 125_000_000;
   localparam int TICK_TIME_MS = 1;
   localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_TIME_MS;
   localparam int PROTECT_TIME_MS = 1500;
   localparam int INIT_TIME_MS = 200;
   localparam logic [15:0] PROTECT_MS = 16'(PROTECT_TIME_MS);
   localparam logic [15:0] INIT_MS = 16'(INIT_TIME_MS);
   localparam logic [15:0] SPEED_LIMIT_RPM = 16'h001E;
   localparam int MAX_DRIVERS = 15;
   localparam logic [3:0] STATION_MIN = 4'h1;
   localparam logic [3:0] STATION_MAX = 4'hF;
   typedef enum {LINK_RS232_SINGLE, LINK_RS232_CHAIN, LINK_RS485_ONLY} link_mode_t;
   // Sequence setting bit positions
   localparam int SEQ_DB_DECEL = 0;
   localparam int SEQ_DB_STOP = 1;
   localparam int SEQ_ENERGISED = 2;
   // Host register byte offsets
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_IRQ_STATUS = 4'h8;
   localparam logic [3:0] REG_IRQ_MASK = 4'hC;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_FWD_BIT = 1;
   localparam int CTRL_REV_BIT = 2;
   localparam int STAT_READY_BIT = 0;
   localparam int STAT_ON_BIT = 1;
   localparam int STAT_BRAKE_BIT = 2;
   localparam int STAT_ALARM_BIT = 3;
   localparam int IRQ_READY_BIT = 0;
   localparam int IRQ_ALARM_BIT = 1;
   localparam int IRQ_OFF_BIT = 2;
   localparam logic [2:0] CTRL_RESET = 3'h0;
   localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
   typedef enum {S_INIT, S_OFF, S_ON, S_STALL_HOLD, S_MOTION_WAIT, S_ALARM} dev_state_t;
endpackage : servo_pkg

/* servo_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface servo_if;
   logic servo_enable_in;
   logic forward_overtravel_in;
   logic reverse_overtravel_in;
   logic servo_ready;
   logic brake_release_out;
   logic servo_on;
   logic alarm;
   modport host (
      output servo_enable_in,
      output forward_overtravel_in,
      output reverse_overtravel_in,
      input servo_ready,
      input brake_release_out,
      input servo_on,
      input alarm
   );
   modport device (
      input servo_enable_in,
      input forward_overtravel_in,
      input reverse_overtravel_in,
      output servo_ready,
      output brake_release_out,
      output servo_on,
      output alarm
   );
endinterface : servo_if
`default_nettype wire

/* tick_divider.sv */
`timescale 1ns/10ps
`default_nettype none
module tick_divider #(
   parameter int DIV = servo_pkg::MS_CYCLES
) (
   input wire logic clk_sys, // System clock
   input wire logic rst,     // Synchronous reset
   output logic tick         // One-cycle enable pulse
);
   import servo_pkg::*;
   localparam int W = $clog2(DIV);
   localparam logic [W-1:0] LAST = W'(DIV - 1);
   if (DIV < 2) begin : g_div_check
      $error("tick_divider needs DIV of at least 2");
   end
   typedef struct packed {
      logic [W-1:0] cnt;
      logic tick;
   } div_state_t;
   div_state_t s_r;
   div_state_t s_nxt;
   always_comb begin
      s_nxt = s_r;
      s_nxt.tick = (s_r.cnt == LAST);
      s_nxt.cnt = (s_r.cnt == LAST) ? '0 : W'(s_r.cnt + 1'b1);
   end
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign tick = s_r.tick;
endmodule : tick_divider
`default_nettype wire

/* servo_host_end.sv */
`timescale 1ns/10ps
`default_nettype none
module servo_host_end #(
   parameter int NUM_DRIVERS = servo_pkg::MAX_DRIVERS,
   parameter servo_pkg::link_mode_t LINK_MODE = servo_pkg::LINK_RS485_ONLY
) (
   input wire logic clk_sys,              // System clock
   input wire logic rst,                  // Synchronous reset
   servo_if.host link,                    // Signals to and from driver
   input wire logic [3:0] avs_address,    // Byte address
   input wire logic avs_read,             // Read request
   input wire logic avs_write,            // Write request
   input wire logic [31:0] avs_writedata, // Write data
   output logic [31:0] avs_readdata,      // Read data
   output logic avs_waitrequest,          // Stall until answered
   output logic irq                       // Level interrupt
);
   import servo_pkg::*;

   ////////////////////////////////////////////////////////////////////////////

   if ((NUM_DRIVERS < 1) || (NUM_DRIVERS > MAX_DRIVERS)) begin : g_count_check
      $error("servo_host_end NUM_DRIVERS out of range");
   end
   if ((LINK_MODE == LINK_RS232_SINGLE) && (NUM_DRIVERS != 1)) begin : g_link_check
      $error("servo_host_end single link needs one driver");
   end

   typedef struct packed {
      logic [2:0] ctrl;
      logic en_out;
      logic [3:0] st_s1;
      logic [3:0] st_s2;
      logic [3:0] st_prev;
      logic [2:0] irq_st;
      logic [2:0] mask;
      logic [31:0] rdata;
      logic wait_r;
      logic irq;
   } host_state_t;

   host_state_t s_r;
   host_state_t s_nxt;
   logic acc;
   logic clr;
   logic decel;
   logic [2:0] ev;

   always_comb begin
      s_nxt = s_r;
      s_nxt.st_s1 = {link.alarm, link.brake_release_out, link.servo_on, link.servo_ready};
      s_nxt.st_s2 = s_r.st_s1;
      s_nxt.st_prev = s_r.st_s2;
      ev = 3'h0;
      ev[IRQ_READY_BIT] = s_r.st_s2[STAT_READY_BIT] && !s_r.st_prev[STAT_READY_BIT];
      ev[IRQ_ALARM_BIT] = s_r.st_s2[STAT_ALARM_BIT] && !s_r.st_prev[STAT_ALARM_BIT];
      ev[IRQ_OFF_BIT] = !s_r.st_s2[STAT_ON_BIT] && s_r.st_prev[STAT_ON_BIT];
      acc = (avs_read || avs_write) && s_r.wait_r;
      clr = acc && avs_read && (avs_address == REG_IRQ_STATUS);
      s_nxt.wait_r = !acc;
      // Write lands at the edge that sees waitrequest low
      if (avs_write && !s_r.wait_r) begin
         if (avs_address == REG_CTRL) begin
            s_nxt.ctrl = avs_writedata[2:0];
         end
         if (avs_address == REG_IRQ_MASK) begin
            s_nxt.mask = avs_writedata[2:0];
         end
      end
      if (acc && avs_read) begin
         case (avs_address)
            REG_CTRL: s_nxt.rdata = {29'h0, s_r.ctrl};
            REG_STATUS: s_nxt.rdata = {28'h0, s_r.st_s2};
            REG_IRQ_STATUS: s_nxt.rdata = {29'h0, s_r.irq_st};
            REG_IRQ_MASK: s_nxt.rdata = {29'h0, s_r.mask};
            default: s_nxt.rdata = 32'h0000_0000;
         endcase
      end
      // New events win over the read clear
      s_nxt.irq_st = (clr ? 3'h0 : s_r.irq_st) | ev;
      s_nxt.irq = |(s_nxt.irq_st & s_nxt.mask);
      decel = s_r.st_s2[STAT_BRAKE_BIT] && !s_r.st_s2[STAT_ON_BIT];
      s_nxt.en_out = s_r.ctrl[CTRL_EN_BIT] && !(decel && !s_r.en_out);
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_r <= '0;
         s_r.ctrl <= CTRL_RESET;
         s_r.mask <= IRQ_MASK_RESET;
         s_r.wait_r <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////

   assign link.servo_enable_in = s_r.en_out;
   assign link.forward_overtravel_in = s_r.ctrl[CTRL_FWD_BIT];
   assign link.reverse_overtravel_in = s_r.ctrl[CTRL_REV_BIT];
   assign avs_readdata = s_r.rdata;
   assign avs_waitrequest = s_r.wait_r;
   assign irq = s_r.irq;
endmodule : servo_host_end
`default_nettype wire

/* servo_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module servo_assertions #(
   parameter int MS_DIV = 4
) (
   input wire logic clk_sys, // System clock
   input wire logic rst, // Synchronous reset
   input wire logic servo_enable_in, // Host enable
   input wire logic servo_ready, // Device ready
   input wire logic brake_release_out, // Brake released
   input wire logic servo_on, // Servo on
   input wire logic alarm // Alarm level
);
   import servo_pkg::*;
   localparam int INIT_CYC = INIT_TIME_MS * MS_DIV - MS_DIV;
   localparam int PROT_CYC = PROTECT_TIME_MS * MS_DIV - MS_DIV;
   logic [15:0] since_r;
   logic [15:0] since_nxt;
   // Cycles since reset release, saturating
   always_comb begin
      since_nxt = (since_r == 16'hFFFF) ? since_r : since_r + 16'h0001;
   end
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         since_r <= 16'h0000;
      end else begin
         since_r <= since_nxt;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////
   ready_after_init_a: assert property (servo_ready |-> since_r >= INIT_CYC)
      else $error("ready before init time");
   on_after_init_a: assert property ($rose(servo_on) |-> since_r >= INIT_CYC)
      else $error("servo on before init time");
   alarm_after_protect_a: assert property (alarm |-> since_r >= PROT_CYC)
      else $error("alarm before supervision active");
   on_needs_ready_a: assert property ($rose(servo_on) |-> servo_ready && !alarm)
      else $error("servo on without ready");
   on_needs_enable_a: assert property ($rose(servo_on) |-> $past(servo_enable_in))
      else $error("servo on without enable");
   brake_rise_on_a: assert property ($rose(brake_release_out) |-> servo_on)
      else $error("brake released while off");
   alarm_forces_off_a: assert property (alarm |-> !servo_on)
      else $error("servo on during alarm");
   off_bounded_a: assert property ($fell(servo_enable_in) |-> ##[1:1000] !servo_on)
      else $error("servo off not reached");
endmodule : servo_assertions
`default_nettype wire

/* testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import servo_pkg::*;
   logic clk_sys, rst, main_power_in, fault_in, avs_read, avs_write, avs_waitrequest, irq;
   logic energise_out, dyn_brake_out, protect_active_out, travel_inhibit_out, station_valid_out;
   logic [15:0] motor_speed_in;
   logic [7:0] stall_set, motion_set;
   logic [2:0] alm_seq, off_seq;
   logic [3:0] station_selector, avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   int error_cnt, comparisons, n, ticks;
   servo_if link ();
   servo_drive_end #(.MS_DIV(4)) i_servo_drive_end (.clk_sys(clk_sys), .rst(rst), .link(link),
      .main_power_in(main_power_in), .fault_in(fault_in), .motor_speed_in(motor_speed_in),
      .stall_brake_delay_setting(stall_set), .motion_brake_delay_setting(motion_set),
      .alarm_sequence_setting(alm_seq), .servo_off_sequence_setting(off_seq),
      .station_selector(station_selector), .energise_out(energise_out),
      .dyn_brake_out(dyn_brake_out), .protect_active_out(protect_active_out),
      .travel_inhibit_out(travel_inhibit_out), .station_valid_out(station_valid_out));
   servo_host_end i_servo_host_end (.clk_sys(clk_sys), .rst(rst), .link(link),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .irq(irq));
   servo_assertions #(.MS_DIV(4)) i_servo_assertions (.clk_sys(clk_sys), .rst(rst),
      .servo_enable_in(link.servo_enable_in), .servo_ready(link.servo_ready),
      .brake_release_out(link.brake_release_out), .servo_on(link.servo_on), .alarm(link.alarm));
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      ticks <= rst ? 0 : ticks + 1;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic cyc(input int c);
      repeat (c) @(posedge clk_sys);
   endtask : cyc
   // Avalon cycle: hold until waitrequest sampled low, then release
   task automatic av_rw(input logic wr, input logic [3:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clk_sys);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk_sys);
   endtask : av_rw
   task automatic av_chk(input logic [3:0] a, input logic [31:0] exp);
      av_rw(1'b0, a, 32'h0000_0000);
      check(rd, exp);
   endtask : av_chk
   task automatic wait_stat(input logic [31:0] exp, input int lim);
      int k;
      k = 0;
      do begin
         av_rw(1'b0, REG_STATUS, 32'h0000_0000);
         k++;
      end while (rd !== exp && k < lim);
      check(rd, exp);
   endtask : wait_stat
   // Cycles that energise or brake release stay at lvl
   task automatic span(input bit eng, input logic lvl, output int c);
      c = 0;
      while ((eng ? energise_out : link.brake_release_out) === lvl && c < 2000) begin
         @(posedge clk_sys);
         c++;
      end
   endtask : span
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : close_out
   initial begin
      repeat (40000) @(posedge clk_sys);
      error_cnt++;
      close_out();
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      main_power_in = 1'b1;
      fault_in = 1'b0;
      motor_speed_in = 16'h0000;
      stall_set = 8'h05;
      motion_set = 8'h0A;
      alm_seq = 3'h2;
      off_seq = 3'h2;
      station_selector = 4'h1;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      error_cnt = 0;
      comparisons = 0;
      cyc(5);
      rst <= 1'b0;
      cyc(1);
      av_chk(REG_CTRL, 32'h0000_0000);
      av_chk(REG_IRQ_MASK, 32'h0000_0000);
      av_chk(4'h1, 32'h0000_0000);
      for (int i = 0; i < 3; i++) begin
         station_selector <= (i == 0) ? 4'h0 : (i == 1) ? 4'h1 : 4'hF;
         cyc(6);
         check(station_valid_out, 32'(i != 0));
      end
      av_rw(1'b1, REG_CTRL, 32'h0000_0001);
      cyc(550);
      av_chk(REG_STATUS, 32'h0000_0000);
      wait_stat(32'h0000_0007, 150);
      av_rw(1'b1, REG_IRQ_MASK, 32'h0000_0007);
      cyc(2);
      check(irq, 32'h1);
      av_chk(REG_IRQ_STATUS, 32'h0000_0001);
      cyc(2);
      check(irq, 32'h0);
      $display("test init done");
      av_rw(1'b1, REG_CTRL, 32'h0000_0000);
      span(1'b0, 1'b1, n);
      span(1'b1, 1'b1, n);
      check(n >= 15 && n <= 26, 32'h1);
      cyc(4);
      check(dyn_brake_out, 32'h1);
      wait_stat(32'h0000_0001, 20);
      av_chk(REG_IRQ_STATUS, 32'h0000_0004);
      $display("test stall off done");
      av_rw(1'b1, REG_CTRL, 32'h0000_0001);
      wait_stat(32'h0000_0007, 20);
      motor_speed_in <= 16'd1000;
      off_seq <= 3'h1;
      cyc(4);
      av_rw(1'b1, REG_CTRL, 32'h0000_0000);
      span(1'b1, 1'b1, n);
      span(1'b0, 1'b1, n);
      check(n >= 35 && n <= 46, 32'h1);
      check(dyn_brake_out, 32'h1);
      av_rw(1'b1, REG_CTRL, 32'h0000_0001);
      cyc(100);
      check(link.servo_on, 32'h0);
      motor_speed_in <= 16'h0000;
      wait_stat(32'h0000_0007, 20);
      motion_set <= 8'hC8;
      motor_speed_in <= 16'd1000;
      cyc(4);
      av_rw(1'b1, REG_CTRL, 32'h0000_0000);
      span(1'b1, 1'b1, n);
      av_rw(1'b1, REG_CTRL, 32'h0000_0001);
      cyc(14);
      check(link.servo_enable_in, 32'h0);
      motor_speed_in <= 16'd29;
      span(1'b0, 1'b1, n);
      check(n <= 12, 32'h1);
      cyc(8);
      check(link.servo_on, 32'h1);
      motor_speed_in <= 16'h0000;
      $display("test motion off done");
      av_rw(1'b1, REG_CTRL, 32'h0000_0001);
      wait_stat(32'h0000_0007, 20);
      av_rw(1'b0, REG_IRQ_STATUS, 32'h0000_0000);
      fault_in <= 1'b1;
      n = 0;
      while (protect_active_out !== 1'b1 && n < 8000) begin
         @(posedge clk_sys);
         n++;
      end
      check(ticks >= 5990 && ticks <= 6010, 32'h1);
      n = 0;
      while (link.alarm !== 1'b1 && n < 50) begin
         @(posedge clk_sys);
         n++;
      end
      check({link.servo_on, link.brake_release_out, energise_out}, 32'h0);
      cyc(4);
      check(dyn_brake_out, 32'h1);
      check(irq, 32'h1);
      av_rw(1'b1, REG_IRQ_MASK, 32'h0000_0000);
      cyc(2);
      check(irq, 32'h0);
      av_chk(REG_IRQ_STATUS, 32'h0000_0006);
      av_rw(1'b1, REG_CTRL, 32'h0000_0002);
      fault_in <= 1'b0;
      wait_stat(32'h0000_0001, 20);
      check(travel_inhibit_out, 32'h1);
      main_power_in <= 1'b0;
      wait_stat(32'h0000_0000, 20);
      $display("test alarm done");
      close_out();
   end
endmodule : testbench
`default_nettype wire
